// [design/gps_consts.svh]
// constants of the gesture/proximity sensor controller
// included only by the gps_ctrl module
`ifndef GPS_CONSTS_SVH
`define GPS_CONSTS_SVH
`define GPS_SLAVE_ADDR 7'h45
`define GPS_CLK_MHZ 100
`define GPS_PULSE_US 9
`define GPS_PULSE_CYC (`GPS_PULSE_US * `GPS_CLK_MHZ)
`define GPS_INTP_US 1
`define GPS_INTP_CYC (`GPS_INTP_US * `GPS_CLK_MHZ)
`define GPS_CONV14_US 6250
`define GPS_CONV12_US 1560
`define GPS_CONV10_US 390
`define GPS_CONV8_US 100
`define GPS_GAP1_US 1560
`define GPS_GAP2_US 6250
`define GPS_GAP3_US 25000
`define GPS_A_CMD1 8'h00
`define GPS_A_CMD2 8'h01
`define GPS_A_PS1 8'h02
`define GPS_A_PS2 8'h03
`define GPS_A_TL 8'h04
`define GPS_A_TH 8'h06
`define GPS_A_OS 8'h08
`define GPS_A_RES 8'h10
`define GPS_A_LAST 8'h19
`define GPS_B_OPER 7
`define GPS_B_CONT 6
`define GPS_B_PRESENCE_STATUS 3
`define GPS_B_FLAG 2
`define GPS_B_PIN 2
`define GPS_B_ITYPE 1
`define GPS_B_RST 0
`define GPS_RST_REG 8'h00
`define GPS_RST_TH 8'hff
`define GPS_SEL_SUM 3'h4
`endif

// [design/gps_pkg.sv]
// types shared by the sensor controller modules
// no assumptions beyond the constants header
package gps_pkg;
  typedef logic [13:0] gps_samp_t;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000,
    I_RX = 3'b001,
    I_ACK = 3'b010,
    I_TX = 3'b011,
    I_MACK = 3'b100
  } gps_i2c_e;
  typedef enum logic [2:0] {
    M_OFF = 3'b000,
    M_ON = 3'b001,
    M_AMB = 3'b010,
    M_CONV = 3'b011,
    M_GAP = 3'b100
  } gps_meas_e;
endpackage

// [design/gps_sync.sv]
// two-flop synchroniser for pin inputs
// inputs are asynchronous to clk
`timescale 1ns/1ps
module gps_sync #(parameter int W = 2) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // gps_sync

// [design/gps_persist.sv]
// persistence filter and hysteresis compare of the event source
// upd is a one-cycle strobe with value stable in that cycle
`timescale 1ns/1ps
module gps_persist (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic upd,
  input wire logic [15:0] value,
  input wire logic [15:0] lower,
  input wire logic [15:0] upper,
  input wire logic [2:0] persist,
  input wire logic presence_status_clr,
  input wire logic flag_clr,
  output logic presence_status,
  output logic flag,
  output logic flag_set
);
  logic [2:0] hi_cnt_r, lo_cnt_r;
  wire hit_hi = value > upper;
  wire hit_lo = value < lower;
  // counts hold earlier consecutive hits, so a setting of 0 fires at once
  wire fire_hi = upd && hit_hi && (hi_cnt_r >= persist);
  wire fire_lo = upd && hit_lo && (lo_cnt_r >= persist);
  wire [2:0] hi_nxt = hit_hi ? ((hi_cnt_r == 3'h7) ? hi_cnt_r : hi_cnt_r + 3'h1) : 3'h0;
  wire [2:0] lo_nxt = hit_lo ? ((lo_cnt_r == 3'h7) ? lo_cnt_r : lo_cnt_r + 3'h1) : 3'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_r <= 3'h0;
      lo_cnt_r <= 3'h0;
      presence_status <= 1'b0;
      flag <= 1'b0;
      flag_set <= 1'b0;
    end else if (clr) begin
      hi_cnt_r <= 3'h0;
      lo_cnt_r <= 3'h0;
      presence_status <= 1'b0;
      flag <= 1'b0;
      flag_set <= 1'b0;
    end else begin
      if (upd) begin
        hi_cnt_r <= hi_nxt;
        lo_cnt_r <= lo_nxt;
      end
      flag_set <= fire_hi || fire_lo;
      // set wins over a host clear in the same cycle
      if (fire_hi) presence_status <= 1'b1;
      else if (fire_lo || presence_status_clr) presence_status <= 1'b0;
      if (fire_hi || fire_lo) flag <= 1'b1;
      else if (flag_clr) flag <= 1'b0;
    end
  end

  AST_FLAG_ON_UPD: assert property (@(posedge clk) disable iff (!resetn)
    $rose(flag) |-> $past(upd))
    else $error("event flag rose without a measurement");
  AST_PRESENCE_STATUS_HIGH: assert property (@(posedge clk) disable iff (!resetn)
    $rose(presence_status) |-> $past(upd && (value > upper)))
    else $error("presence rose without upper limit exceeded");
  AST_NO_EARLY: assert property (@(posedge clk) disable iff (!resetn)
    (upd && !clr && (!hit_hi || hi_cnt_r < persist) && (!hit_lo || lo_cnt_r < persist)) |=> !flag_set)
    else $error("event fired before persistence count");
endmodule // gps_persist

// [design/gps_ctrl.sv]
// top of the gesture/proximity sensor control: i2c slave, registers,
// measurement sequencer, offset, event pin
// assumes adc_raw* are stable results from the front end on clk
// Functional notes
// - answer only slave address 1000101, bit0 direction
// - write bytes advance pointer until stop
// - presence and event bits not host-settable
// - result registers 10h-19h are read-only
// - master ack reads next address, nack ends
// - repeated start accepted before read address
// - never stretch scl, ignore general call
// - four 14-bit samples and 16-bit sum readable
// - event when below lower or above upper
// - compare source chosen by select field
// - shutdown stops all but i2c port
// - continuous or single shot then shutdown
// - output changes on n+1 consecutive hits
// - bit depth sets conversion time
// - gain scale field sets measurable range
// - idle gap between measurements when continuous
// - led peak current from drive field
// - pin shows event flag or presence
// - burst of 1 to 128 9us pulses
// - soft init resets registers, self-clears
// - subtract channel offset from raw value
// - led-on minus led-off charge, then convert
// - host clears status bits writing zero
// - select codes 0-3 channels, 4 sum
`timescale 1ns/1ps
`include "gps_consts.svh"
module gps_ctrl #(
  parameter int CONV14_CYC = `GPS_CONV14_US * `GPS_CLK_MHZ,
  parameter int CONV12_CYC = `GPS_CONV12_US * `GPS_CLK_MHZ,
  parameter int CONV10_CYC = `GPS_CONV10_US * `GPS_CLK_MHZ,
  parameter int CONV8_CYC = `GPS_CONV8_US * `GPS_CLK_MHZ,
  parameter int GAP1_CYC = `GPS_GAP1_US * `GPS_CLK_MHZ,
  parameter int GAP2_CYC = `GPS_GAP2_US * `GPS_CLK_MHZ,
  parameter int GAP3_CYC = `GPS_GAP3_US * `GPS_CLK_MHZ
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire gps_pkg::gps_samp_t adc_raw0,
  input wire gps_pkg::gps_samp_t adc_raw1,
  input wire gps_pkg::gps_samp_t adc_raw2,
  input wire gps_pkg::gps_samp_t adc_raw3,
  output logic led_on,
  output logic integ_sub,
  output logic conv_active,
  output logic front_end_en,
  output logic [2:0] led_drive_level,
  output logic [2:0] range_sel,
  output logic [1:0] adc_bit_depth,
  output logic event_pin_n
);
  import gps_pkg::*;
  localparam int PULSE_CYC = `GPS_PULSE_CYC;
  localparam int INTP_CYC = `GPS_INTP_CYC;
  localparam logic [6:0] SLV = `GPS_SLAVE_ADDR;

  // ---- pin sampling
  logic [1:0] pin_s;
  logic scl_d_r, sda_d_r;
  gps_sync #(.W(2)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({scl_i, sda_i}),
    .q(pin_s)
  );
  wire scl_s = pin_s[1];
  wire sda_s = pin_s[0];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_c = scl_s && scl_d_r && !sda_s && sda_d_r;
  wire stop_c = scl_s && scl_d_r && sda_s && !sda_d_r;

  // ---- register storage
  logic [7:0] cfg_r [1:15];
  logic oper_r, cont_r, rst_pend_r;
  gps_samp_t samp_r [0:3];
  logic [15:0] sum_r;
  logic presence_status, flag, flag_set;
  logic [7:0] ptr_r, wa_r, sh_r, tx_r;
  logic wr_stb_r;

  function automatic logic [7:0] init_val(input int idx);
    init_val = (idx == 6 || idx == 7) ? `GPS_RST_TH : `GPS_RST_REG;
  endfunction

  wire [7:0] wd = sh_r;
  wire wr_cmd1 = wr_stb_r && (wa_r == `GPS_A_CMD1);
  wire wr_cfg = wr_stb_r && (wa_r > `GPS_A_CMD1) && (wa_r < `GPS_A_RES);
  wire soft_rst = rst_pend_r;
  wire presence_status_clr = wr_cmd1 && !wd[`GPS_B_PRESENCE_STATUS];
  wire flag_clr = wr_cmd1 && !wd[`GPS_B_FLAG];
  logic auto_off;

  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++) begin : g_cfg
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) cfg_r[gi] <= init_val(gi);
        else if (soft_rst) cfg_r[gi] <= init_val(gi);
        else if (wr_cfg && (wa_r[3:0] == 4'(gi))) cfg_r[gi] <= (gi == 1) ? (wd & 8'hfe) : wd;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oper_r <= 1'b0;
      cont_r <= 1'b0;
      rst_pend_r <= 1'b0;
    end else begin
      rst_pend_r <= wr_stb_r && (wa_r == `GPS_A_CMD2) && wd[`GPS_B_RST];
      if (soft_rst) begin
        oper_r <= 1'b0;
        cont_r <= 1'b0;
      end else if (wr_cmd1) begin
        // only the mode bits are stored; status bits are hardware owned
        oper_r <= wd[`GPS_B_OPER];
        cont_r <= wd[`GPS_B_CONT];
      end else if (auto_off) oper_r <= 1'b0;
    end
  end

  wire [2:0] irq_source_select = cfg_r[1][5:3];
  wire [1:0] idle_gap_select = cfg_r[1][7:6];
  wire pin_sel = cfg_r[1][`GPS_B_PIN];
  wire irq_pulse_mode = cfg_r[1][`GPS_B_ITYPE];
  wire [2:0] persistence_count = cfg_r[2][7:5];
  wire [1:0] depth_sel = cfg_r[2][4:3];
  wire [2:0] led_burst_count = cfg_r[3][4:2];
  wire [15:0] lower_limit = {cfg_r[5], cfg_r[4]};
  wire [15:0] upper_limit = {cfg_r[7], cfg_r[6]};

  // ---- read decode
  wire [1:0] rch = ptr_r[2:1];
  wire [7:0] rd_res = ptr_r[0] ? {2'b00, samp_r[rch][13:8]} : samp_r[rch][7:0];
  wire [7:0] rd_sum = ptr_r[0] ? sum_r[15:8] : sum_r[7:0];
  wire [7:0] rd_st = {oper_r, cont_r, 2'b00, presence_status, flag, 2'b00};
  wire [7:0] rd_data = (ptr_r == `GPS_A_CMD1) ? rd_st :
                       (ptr_r < `GPS_A_RES) ? cfg_r[ptr_r[3:0]] :
                       (ptr_r < 8'h18) ? rd_res :
                       (ptr_r <= `GPS_A_LAST) ? rd_sum : 8'h00;

  // ---- i2c slave; sda only ever pulled low, scl never driven
  gps_i2c_e ist_r;
  logic first_r, word_r, rw_r, got_r, oe_r;
  logic [2:0] bit_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ist_r <= I_IDLE;
      first_r <= 1'b0;
      word_r <= 1'b0;
      rw_r <= 1'b0;
      got_r <= 1'b0;
      oe_r <= 1'b0;
      bit_r <= 3'h0;
      ptr_r <= 8'h00;
      wa_r <= 8'h00;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      wr_stb_r <= 1'b0;
    end else begin
      wr_stb_r <= 1'b0;
      if (start_c) begin
        ist_r <= I_RX;
        first_r <= 1'b1;
        bit_r <= 3'h0;
        got_r <= 1'b0;
        oe_r <= 1'b0;
      end else if (stop_c) begin
        ist_r <= I_IDLE;
        oe_r <= 1'b0;
      end else begin
        unique case (ist_r)
          I_IDLE: ;
          I_RX: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_r <= bit_r + 3'h1;
              got_r <= (bit_r == 3'h7);
            end else if (scl_fall && got_r) begin
              got_r <= 1'b0;
              ist_r <= I_ACK;
              oe_r <= 1'b1;
              if (first_r) begin
                first_r <= 1'b0;
                rw_r <= sh_r[0];
                word_r <= !sh_r[0];
                if (sh_r[7:1] != SLV) begin
                  ist_r <= I_IDLE;
                  oe_r <= 1'b0;
                end
              end else if (word_r) begin
                word_r <= 1'b0;
                ptr_r <= sh_r;
              end else begin
                // acked even when the target ignores the data
                wr_stb_r <= 1'b1;
                wa_r <= ptr_r;
                ptr_r <= ptr_r + 8'h01;
              end
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              bit_r <= 3'h0;
              if (rw_r) begin
                ist_r <= I_TX;
                tx_r <= rd_data;
                oe_r <= !rd_data[7];
              end else begin
                ist_r <= I_RX;
                oe_r <= 1'b0;
              end
            end
          end
          I_TX: begin
            if (scl_fall) begin
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                ist_r <= I_MACK;
                oe_r <= 1'b0;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                oe_r <= !tx_r[6];
              end
            end
          end
          I_MACK: begin
            if (scl_rise) begin
              if (sda_s) ist_r <= I_IDLE;
              else ptr_r <= ptr_r + 8'h01;
            end else if (scl_fall) begin
              ist_r <= I_TX;
              tx_r <= rd_data;
              oe_r <= !rd_data[7];
              bit_r <= 3'h0;
            end
          end
          default: ist_r <= I_IDLE;
        endcase
      end
    end
  end

  // ---- measurement sequencer
  gps_meas_e mst_r;
  logic [21:0] cnt_r;
  logic [7:0] pulses_r;
  logic done_r;
  wire [7:0] burst = 8'h01 << led_burst_count;
  wire [21:0] conv_len = (depth_sel == 2'b00) ? 22'(CONV14_CYC) :
                         (depth_sel == 2'b01) ? 22'(CONV12_CYC) :
                         (depth_sel == 2'b10) ? 22'(CONV10_CYC) : 22'(CONV8_CYC);
  wire [21:0] gap_len = (idle_gap_select == 2'b01) ? 22'(GAP1_CYC) :
                        (idle_gap_select == 2'b10) ? 22'(GAP2_CYC) : 22'(GAP3_CYC);
  wire [21:0] cur_len = (mst_r == M_CONV) ? conv_len : (mst_r == M_GAP) ? gap_len : 22'(PULSE_CYC);
  wire cnt_end = (cnt_r == cur_len - 22'h1);
  wire conv_end = (mst_r == M_CONV) && cnt_end;
  assign auto_off = conv_end && !cont_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mst_r <= M_OFF;
      cnt_r <= 22'h0;
      pulses_r <= 8'h00;
    end else if (soft_rst || !oper_r) begin
      mst_r <= M_OFF;
      cnt_r <= 22'h0;
      pulses_r <= 8'h00;
    end else begin
      cnt_r <= (cnt_end || mst_r == M_OFF) ? 22'h0 : cnt_r + 22'h1;
      unique case (mst_r)
        M_OFF: mst_r <= M_ON;
        M_ON: if (cnt_end) mst_r <= M_AMB;
        M_AMB: begin
          if (cnt_end) begin
            pulses_r <= pulses_r + 8'h01;
            mst_r <= (pulses_r + 8'h01 == burst) ? M_CONV : M_ON;
          end
        end
        M_CONV: begin
          if (cnt_end) begin
            pulses_r <= 8'h00;
            mst_r <= !cont_r ? M_OFF : (idle_gap_select == 2'b00) ? M_ON : M_GAP;
          end
        end
        M_GAP: if (cnt_end) mst_r <= M_ON;
        default: mst_r <= M_OFF;
      endcase
    end
  end

  // ---- results: depth scaling then offset with floor at zero
  gps_samp_t raw [0:3];
  gps_samp_t net [0:3];
  assign raw[0] = adc_raw0;
  assign raw[1] = adc_raw1;
  assign raw[2] = adc_raw2;
  assign raw[3] = adc_raw3;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      wire [13:0] scaled = raw[gi] >> {depth_sel, 1'b0};
      wire [13:0] ofs = {cfg_r[9 + 2 * gi][5:0], cfg_r[8 + 2 * gi]};
      assign net[gi] = (scaled > ofs) ? scaled - ofs : 14'h0;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) samp_r[gi] <= 14'h0;
        else if (soft_rst) samp_r[gi] <= 14'h0;
        else if (conv_end) samp_r[gi] <= net[gi];
      end
    end
  endgenerate
  wire [15:0] sum_nxt = 16'(net[0]) + 16'(net[1]) + 16'(net[2]) + 16'(net[3]);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sum_r <= 16'h0;
      done_r <= 1'b0;
    end else begin
      done_r <= conv_end && !soft_rst;
      if (soft_rst) sum_r <= 16'h0;
      else if (conv_end) sum_r <= sum_nxt;
    end
  end

  // ---- event compare; illegal select codes never update
  wire sel_ok = irq_source_select <= `GPS_SEL_SUM;
  wire [15:0] src_val = (irq_source_select == `GPS_SEL_SUM) ? sum_r :
                        16'(samp_r[irq_source_select[1:0]]);
  gps_persist u_persist (
    .clk(clk),
    .resetn(resetn),
    .clr(soft_rst),
    .upd(done_r && sel_ok),
    .value(src_val),
    .lower(lower_limit),
    .upper(upper_limit),
    .persist(persistence_count),
    .presence_status_clr(presence_status_clr),
    .flag_clr(flag_clr),
    .presence_status(presence_status),
    .flag(flag),
    .flag_set(flag_set)
  );

  // ---- registered outputs
  logic [6:0] ipc_r;
  wire irq_act = pin_sel ? presence_status : (irq_pulse_mode ? (ipc_r != 7'h0) : flag);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ipc_r <= 7'h0;
      event_pin_n <= 1'b1;
      sda_o <= 1'b0;
      sda_oe <= 1'b0;
      led_on <= 1'b0;
      integ_sub <= 1'b0;
      conv_active <= 1'b0;
      front_end_en <= 1'b0;
      led_drive_level <= 3'h0;
      range_sel <= 3'h0;
      adc_bit_depth <= 2'h0;
    end else begin
      ipc_r <= flag_set ? 7'(INTP_CYC) : (ipc_r != 7'h0) ? ipc_r - 7'h1 : 7'h0;
      event_pin_n <= !irq_act;
      sda_o <= 1'b0;
      sda_oe <= oe_r;
      led_on <= (mst_r == M_ON);
      integ_sub <= (mst_r == M_AMB);
      conv_active <= (mst_r == M_CONV);
      front_end_en <= (mst_r != M_OFF);
      led_drive_level <= cfg_r[3][7:5];
      range_sel <= cfg_r[2][2:0];
      adc_bit_depth <= depth_sel;
    end
  end

  AST_FOREIGN_ADDR: assert property (@(posedge clk) disable iff (!resetn)
    (ist_r == I_RX && first_r && got_r && scl_fall && !start_c && !stop_c && sh_r[7:1] != SLV)
    |=> (ist_r == I_IDLE) ##1 !sda_oe)
    else $error("foreign address was acknowledged");
  AST_GENCALL: assert property (@(posedge clk) disable iff (!resetn)
    (ist_r == I_RX && first_r && got_r && scl_fall && !start_c && sh_r[7:1] == 7'h00) |=> ##1 !sda_oe)
    else $error("general call was acknowledged");
  AST_PTR_STEP: assert property (@(posedge clk) disable iff (!resetn)
    wr_stb_r |-> (ptr_r == wa_r + 8'h01))
    else $error("pointer did not advance after a write byte");
  AST_RO_RES: assert property (@(posedge clk) disable iff (!resetn)
    (wr_stb_r && wa_r >= `GPS_A_RES && !conv_end && !soft_rst) |=> $stable(sum_r))
    else $error("host write changed a result register");
  AST_SOFT_INIT: assert property (@(posedge clk) disable iff (!resetn)
    rst_pend_r |=> (cfg_r[6] == 8'hff && cfg_r[1] == 8'h00 && !oper_r && !rst_pend_r))
    else $error("soft init did not restore initial values");
  AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!resetn)
    !oper_r |=> (mst_r == M_OFF) ##1 !front_end_en)
    else $error("sequencer ran in shutdown");
  AST_ONESHOT: assert property (@(posedge clk) disable iff (!resetn)
    (conv_end && !cont_r && !wr_cmd1 && !soft_rst) |=> (!oper_r && mst_r == M_OFF))
    else $error("single shot did not shut down");
  AST_PULSE_LEN: assert property (@(posedge clk) disable iff (!resetn)
    (mst_r == M_ON && $past(mst_r) != M_ON && oper_r) |-> (mst_r == M_ON || !oper_r || soft_rst)[*8])
    else $error("led pulse ended early");
endmodule // gps_ctrl

// [bench/gps_host.sv]
// i2c bus master model standing in for the host controller
// assumes sda has a pull-up; scl is driven push-pull by this model only
`timescale 1ns/1ps
module gps_host (
  input wire logic clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic pull;
  // wired-and of both open-drain drivers, pulled up when released
  assign sda = !(sda_oe | pull);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // also a repeated start when scl is already low
  task automatic start();
    w(4);
    pull = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    pull = 1'b1;
    w(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    w(4);
    pull = 1'b1;
    w(4);
    scl = 1'b1;
    w(8);
    pull = 1'b0;
    w(8);
  endtask
  // data moves mid-low so it never looks like start or stop
  task automatic bitx(input logic b, output logic r);
    w(4);
    pull = !b;
    w(4);
    scl = 1'b1;
    w(8);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // the final byte gets a nack to end the read
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule // gps_host

// [bench/gesture_proximity_sensor_ctrl_tb.sv]
// self-checking bench: registers over i2c, one measurement with offsets,
// event pin, read-only places, soft init and shutdown
// assumes gps_host as bus master and shortened conversion counts
`timescale 1ns/1ps
module gesture_proximity_sensor_ctrl_tb;
  import gps_pkg::*;
  logic clk, resetn, scl, sda, sda_oe, led_on, front_end_en, event_pin_n;
  logic sda_o, integ_sub, conv_active;
  logic [2:0] led_drive_level, range_sel, drv, rng;
  logic [1:0] adc_bit_depth;
  gps_samp_t raw [4];
  gps_samp_t off [4];
  gps_samp_t ex [4];
  logic [7:0] buf_q [16];
  logic [7:0] rb_q [16];
  logic led_q = 1'b0;
  logic amb_q = 1'b0;
  int ambs = 0;
  int conv_cyc = 0;
  int low_n = 0;
  int fails = 0;
  int n_checks = 0;
  int pulses = 0;
  gps_host u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  gps_ctrl #(.CONV14_CYC(200), .CONV12_CYC(150), .CONV10_CYC(100), .CONV8_CYC(50),
    .GAP1_CYC(100)) u_dut (
    .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .adc_raw0(raw[0]), .adc_raw1(raw[1]), .adc_raw2(raw[2]), .adc_raw3(raw[3]),
    .led_on(led_on), .integ_sub(integ_sub), .conv_active(conv_active), .front_end_en(front_end_en),
    .led_drive_level(led_drive_level), .range_sel(range_sel),
    .adc_bit_depth(adc_bit_depth), .event_pin_n(event_pin_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (led_on && !led_q)
      pulses++;
    if (integ_sub && !amb_q)
      ambs++;
    if (conv_active)
      conv_cyc++;
    if (!event_pin_n)
      low_n++;
    led_q <= led_on;
    amb_q <= integ_sub;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic head(input logic [7:0] a);
    logic ack;
    u_host.start();
    u_host.put(8'h8a, ack);
    chk(16'(ack), 16'h1);
    u_host.put(a, ack);
    chk(16'(ack), 16'h1);
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    logic ack;
    head(a);
    for (int i = 0; i < n; i++) begin
      u_host.put(buf_q[i], ack);
      chk(16'(ack), 16'h1);
    end
    u_host.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic ack;
    head(a);
    u_host.start();
    u_host.put(8'h8b, ack);
    chk(16'(ack), 16'h1);
    for (int i = 0; i < n; i++)
      u_host.get(i == n - 1, rb_q[i]);
    u_host.stop();
  endtask
  // offset subtraction floors at zero
  function automatic gps_samp_t corr(input gps_samp_t r, input gps_samp_t o);
    return (r > o) ? r - o : 14'h0;
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #1ms;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    logic [15:0] sum;
    logic ack;
    int base;
    void'($urandom(32847));
    resetn = 1'b0;
    // raw kept above every offset so the sum clears a zero upper limit
    for (int i = 0; i < 4; i++) begin
      raw[i] = 14'h2000 | 14'($urandom());
      off[i] = 14'($urandom()) & 14'h0fff;
    end
    drv = 3'($urandom());
    rng = 3'($urandom());
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    u_host.w(6);
    rd(8'h00, 8);
    for (int i = 0; i < 8; i++)
      chk(16'(rb_q[i]), (i >= 6) ? 16'h00ff : 16'h0000);
    buf_q[0] = 8'h24;
    buf_q[1] = {5'h00, rng};
    buf_q[2] = {drv, 5'h08};
    for (int i = 3; i < 7; i++)
      buf_q[i] = 8'h00;
    for (int i = 0; i < 4; i++) begin
      buf_q[7 + 2 * i] = off[i][7:0];
      buf_q[8 + 2 * i] = {2'b00, off[i][13:8]};
    end
    wr(8'h01, 15);
    rd(8'h01, 15);
    for (int i = 0; i < 15; i++)
      chk(16'(rb_q[i]), 16'(buf_q[i]));
    chk(16'(led_drive_level), 16'(drv));
    chk(16'(range_sel), 16'(rng));
    chk(16'(adc_bit_depth), 16'h0);
    chk(16'(event_pin_n), 16'h1);
    buf_q[0] = 8'h80;
    wr(8'h00, 1);
    chk(16'(front_end_en), 16'h1);
    for (int i = 0; i < 20000 && front_end_en !== 1'b0; i++)
      u_host.w(1);
    // pin is registered two edges behind the result latch
    u_host.w(2);
    chk(16'(pulses), 16'h4);
    chk(16'(ambs), 16'h4);
    chk(16'(conv_cyc), 16'd200);
    chk(16'(event_pin_n), 16'h0);
    rd(8'h00, 1);
    chk(16'(rb_q[0]), 16'h000c);
    rd(8'h10, 10);
    sum = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      ex[i] = corr(raw[i], off[i]);
      chk({rb_q[2 * i + 1], rb_q[2 * i]}, {2'b00, ex[i]});
      sum = sum + {2'b00, ex[i]};
    end
    chk({rb_q[9], rb_q[8]}, sum);
    buf_q[0] = 8'hff;
    buf_q[1] = 8'hff;
    wr(8'h10, 2);
    rd(8'h10, 2);
    chk({rb_q[1], rb_q[0]}, {2'b00, ex[0]});
    buf_q[0] = 8'h0c;
    wr(8'h00, 1);
    rd(8'h00, 1);
    chk(16'(rb_q[0]), 16'h000c);
    buf_q[0] = 8'h00;
    wr(8'h00, 1);
    rd(8'h00, 1);
    chk(16'(rb_q[0]), 16'h0000);
    chk(16'(event_pin_n), 16'h1);
    // general call and a neighbouring address must both go unanswered
    for (int i = 0; i < 2; i++) begin
      u_host.start();
      u_host.put(i == 0 ? 8'h00 : 8'h8c, ack);
      chk(16'(ack), 16'h0);
      u_host.stop();
    end
    buf_q[0] = 8'hc0;
    wr(8'h00, 1);
    u_host.w(9000);
    chk(16'(front_end_en), 16'h1);
    buf_q[0] = 8'h00;
    wr(8'h00, 1);
    chk(16'(front_end_en), 16'h0);
    buf_q[0] = 8'h01;
    wr(8'h01, 1);
    rd(8'h01, 7);
    for (int i = 0; i < 7; i++)
      chk(16'(rb_q[i]), (i >= 5) ? 16'h00ff : 16'h0000);
    chk(16'(led_drive_level), 16'h0);
    // channel 0 under a full-scale lower limit, one repeat, pulse pin, short gap
    buf_q[0] = 8'h42;
    buf_q[1] = 8'h38;
    buf_q[2] = 8'h00;
    buf_q[3] = 8'hff;
    buf_q[4] = 8'hff;
    wr(8'h01, 5);
    chk(16'(adc_bit_depth), 16'h3);
    base = low_n;
    buf_q[0] = 8'hc0;
    wr(8'h00, 1);
    u_host.w(3000);
    chk(16'(low_n - base), 16'h0);
    u_host.w(2000);
    // pin pulse is 1 us at 100 MHz
    chk(16'(low_n - base), 16'd100);
    rd(8'h00, 1);
    chk(16'(rb_q[0]), 16'h00c4);
    rd(8'h10, 2);
    chk({rb_q[1], rb_q[0]}, 16'(raw[0] >> 6));
    chk(16'(sda_o), 16'h0);
    end_of_test();
  end
endmodule // gesture_proximity_sensor_ctrl_tb
